//--- pkg/bfs_pkg.sv
`default_nettype none
package bfs_pkg;
  // ****************************************
  // frequency select codes
  // ****************************************
  localparam logic [1:0] BFS_CODE_133MHZ = 2'h3;
  localparam logic [1:0] BFS_CODE_RSVD0 = 2'h0;
  localparam logic [1:0] BFS_CODE_RSVD1 = 2'h1;
  localparam logic [1:0] BFS_CODE_RSVD2 = 2'h2;
  localparam logic [1:0] BFS_RESET_CODE = BFS_CODE_RSVD0;
  // ****************************************
  // power-up timing
  // ****************************************
  localparam int BFS_CLK_MHZ = 200;
  localparam int BFS_SETTLE_NS = 100;
  localparam int BFS_SETTLE_CYC_RAW = (BFS_SETTLE_NS * BFS_CLK_MHZ + 999) / 1000;
  localparam int BFS_SETTLE_CYC = (BFS_SETTLE_CYC_RAW < 1) ? 1 : BFS_SETTLE_CYC_RAW;
  localparam logic [7:0] BFS_SETTLE_CNT = BFS_SETTLE_CYC[7:0];
  typedef enum logic [1:0]
  {
    BFS_ST_OFF = 2'b00,
    BFS_ST_SETTLE = 2'b01,
    BFS_ST_GOOD = 2'b10
  } bfs_state_t;
endpackage
`default_nettype wire

//--- logic/bfs_bus_freq_select.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_bus_freq_select
  import bfs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic supply_ok_in,
  output logic [1:0] bus_freq_select_out,
  output logic [1:0] bus_freq_select_oe_out,
  output logic termination_power_good_out
);
  import bfs_pkg::*;

  // ****************************************
  // supply level synchroniser
  // ****************************************
  logic sup_meta_q;
  logic sup_sync_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      sup_meta_q <= 1'b0;
      sup_sync_q <= 1'b0;
    end
    else
    begin
      sup_meta_q <= supply_ok_in;
      sup_sync_q <= sup_meta_q;
    end
  end

  // ****************************************
  // power-up sequencer
  // ****************************************
  bfs_state_t state_q;
  logic [7:0] cnt_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= BFS_ST_OFF;
      cnt_q <= 8'h00;
    end
    else if (!sup_sync_q)
    begin
      state_q <= BFS_ST_OFF;
      cnt_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        BFS_ST_OFF:
        begin
          state_q <= BFS_ST_SETTLE;
          cnt_q <= 8'h00;
        end
        BFS_ST_SETTLE:
        begin
          // pins must settle before power-good, so a count not a single edge
          if (cnt_q == BFS_SETTLE_CNT - 8'h01)
          begin
            state_q <= BFS_ST_GOOD;
          end
          cnt_q <= cnt_q + 8'h01;
        end
        default:
        begin
          state_q <= BFS_ST_GOOD;
        end
      endcase
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // open drain: a one is released to the pull-up, a zero is pulled down
  // data side tied low so nothing can push a pin above the pull-up rail
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      bus_freq_select_out <= 2'h0;
    end
    else
    begin
      bus_freq_select_out <= 2'h0;
    end
  end

  // code fixed one cycle after the sequencer enters settle; only the reset value is transient
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      bus_freq_select_oe_out <= ~BFS_RESET_CODE;
    end
    else if (state_q == BFS_ST_OFF)
    begin
      bus_freq_select_oe_out <= ~BFS_RESET_CODE;
    end
    else
    begin
      bus_freq_select_oe_out <= ~BFS_CODE_133MHZ;
    end
  end

  // ****************************************
  // power-good output
  // ****************************************
  // registered from the state, so it trails the code by the whole settle window
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      termination_power_good_out <= 1'b0;
    end
    else
    begin
      termination_power_good_out <= (state_q == BFS_ST_GOOD);
    end
  end

  // ****************************************
  // check helpers
  // ****************************************
  // cycles the final code has stood on the pins; saturates rather than wrapping
  logic [7:0] chk_final_cnt_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      chk_final_cnt_q <= 8'h00;
    end
    else if (bus_freq_select_oe_out != ~BFS_CODE_133MHZ)
    begin
      chk_final_cnt_q <= 8'h00;
    end
    else if (chk_final_cnt_q != 8'hff)
    begin
      chk_final_cnt_q <= chk_final_cnt_q + 8'h01;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // pin values
  a_od_low_only: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    bus_freq_select_out == 2'h0)
    else $error("open-drain pin driven high");
  a_code_legal: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    bus_freq_select_oe_out == ~BFS_RESET_CODE || bus_freq_select_oe_out == ~BFS_CODE_133MHZ)
    else $error("unexpected reserved code on the pins");
  a_reset_pins: assert property (@(posedge sys_clk_in)
    srst_in |=> bus_freq_select_oe_out == ~BFS_RESET_CODE && !termination_power_good_out)
    else $error("reset did not return pins to the reset code");
  a_off_reserved: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    state_q == BFS_ST_OFF |=> bus_freq_select_oe_out == ~BFS_RESET_CODE)
    else $error("code driven while supply is off");
  a_supply_cut_oe: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !sup_sync_q |=> ##1 bus_freq_select_oe_out == ~BFS_RESET_CODE)
    else $error("code kept after supply loss");
  a_code_133_set: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (state_q == BFS_ST_SETTLE) |=> bus_freq_select_oe_out == 2'h0)
    else $error("133 MHz code not driven while settling");

  // power-good against the code
  a_good_code_final: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    termination_power_good_out |-> bus_freq_select_oe_out == 2'h0)
    else $error("power-good high while code not 133 MHz");
  a_code_stable_pg: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(termination_power_good_out) |-> $stable(bus_freq_select_oe_out))
    else $error("code changed at power-good rise");
  a_code_held_good: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    termination_power_good_out && $past(termination_power_good_out) |-> $stable(bus_freq_select_oe_out))
    else $error("code moved while power-good high");
  a_pg_after_settle: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(termination_power_good_out) |-> chk_final_cnt_q >= BFS_SETTLE_CNT)
    else $error("power-good rose before the code settled");
  a_pg_settle_time: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(termination_power_good_out) |-> $past(state_q == BFS_ST_SETTLE, 2))
    else $error("power-good without settling");
  a_pg_drops_supply: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !sup_sync_q |=> ##1 !termination_power_good_out)
    else $error("power-good held without supply");

  // sequencer internals
  a_pg_from_good: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    termination_power_good_out |-> $past(state_q == BFS_ST_GOOD))
    else $error("power-good without the good state");
  a_settle_count: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    state_q == BFS_ST_SETTLE |-> cnt_q < BFS_SETTLE_CNT)
    else $error("settle counter overran");
  a_state_needs_supply: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    state_q != BFS_ST_OFF |-> $past(sup_sync_q))
    else $error("sequencer left off without supply");

  // ****************************************
  // cover points
  // ****************************************
  c_power_up: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(termination_power_good_out));
  c_power_drop: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    $fell(termination_power_good_out));
  c_settle: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    state_q == BFS_ST_SETTLE);
  c_settle_done: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    state_q == BFS_ST_SETTLE ##1 state_q == BFS_ST_GOOD);
  c_reset_mid: cover property (@(posedge sys_clk_in)
    termination_power_good_out && srst_in);
endmodule
`default_nettype wire

//--- tb/bfs_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_chipset_model
  import bfs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [1:0] drive_in,
  input wire logic [1:0] oe_in,
  input wire logic pg_in,
  output logic [1:0] pin_out,
  output logic [1:0] latched_out
);
  logic pg_q;
  assign pin_out = (oe_in & drive_in) | ~oe_in;
  // code before power-good may be junk, so latch on the rise only
  always_ff @(posedge sys_clk_in)
  begin
    pg_q <= pg_in;
    if (pg_in && !pg_q)
      latched_out <= pin_out;
  end
endmodule
`default_nettype wire

//--- tb/bus_frequency_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bus_frequency_select_tb_top;
  import bfs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic sup = 1'b0;
  logic [1:0] dout, oe, pin, latched;
  logic pg;
  int n_errors = 0;
  int compares = 0;
  bfs_bus_freq_select u_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .supply_ok_in(sup),
    .bus_freq_select_out(dout), .bus_freq_select_oe_out(oe), .termination_power_good_out(pg));
  bfs_chipset_model u_chip (.sys_clk_in(sys_clk_in), .drive_in(dout), .oe_in(oe), .pg_in(pg),
    .pin_out(pin), .latched_out(latched));
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task automatic end_sim;
  begin
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // bounded wait, then the final code must be on the pins and latched
  task automatic wait_good;
    int i;
  begin
    for (i = 0; i < 60 && pg !== 1'b1; i++)
      @(negedge sys_clk_in);
    cmp({1'b0, pg}, 2'h1);
    cmp(pin, BFS_CODE_133MHZ);
    // the partner latches on the same edge at which it first sees power-good high
    @(negedge sys_clk_in);
    cmp(latched, BFS_CODE_133MHZ);
  end
  endtask
  task automatic t_hold_drop;
  begin
    repeat (30) @(negedge sys_clk_in);
    cmp({pg, pin[0]}, 2'h3);
    sup = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    cmp({1'b0, pg}, 2'h0);
    cmp(pin, BFS_RESET_CODE);
    cmp(latched, BFS_CODE_133MHZ);
    sup = 1'b1;
    wait_good();
    $display("hold and drop done");
  end
  endtask
  task automatic t_reset_mid;
  begin
    srst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    cmp(pin, BFS_RESET_CODE);
    cmp({1'b0, pg}, 2'h0);
    srst_in = 1'b0;
    wait_good();
    $display("reset mid-run done");
  end
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk_in);
    srst_in = 1'b0;
    sup = 1'b1;
    wait_good();
    $display("power up done");
    t_hold_drop();
    t_reset_mid();
    end_sim();
  end
  initial
  begin
    #2000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
